// ==== rtl/ispfb_pkg.sv ====
/*
  Shared constants and types of the in-system programming support block:
  register indices, reset values, key and forced-entry codes, timing counts.
  Assumes a core clock of 25 MHz and an 8-bit register port on the CPU side.
*/
package ispfb_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned DEBOUNCE_NS = 100_000;
  localparam int unsigned DEBOUNCE_CYCLES =
    (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PULSE_UNIT_CYCLES = 16;
  localparam logic [1:0] STARTUP_CYCLES = 2'h3;

  // ==========================================================================
  // Register indices on the CPU register port
  localparam logic [2:0] RA_ADDR_HIGH = 3'h0;
  localparam logic [2:0] RA_ADDR_LOW = 3'h1;
  localparam logic [2:0] RA_READ_BUF = 3'h2;
  localparam logic [2:0] RA_WRITE_BUF = 3'h3;
  localparam logic [2:0] RA_PULSE_TIM = 3'h4;
  localparam logic [2:0] RA_UNLOCK = 3'h5;
  localparam logic [2:0] RA_CONTROL = 3'h6;
  localparam logic [2:0] RA_STATUS = 3'h7;

  // ==========================================================================
  // Reset values and field layout
  localparam logic [7:0] RST_ADDR = 8'h00;
  localparam logic [7:0] RST_PULSE_TIM = 8'h5A;
  localparam logic [7:0] PULSE_TIM_RW_MASK = 8'h7F;
  localparam logic [5:0] UNLOCK_KEY = 6'h26;
  localparam int unsigned UNLOCK_KEY_LSB = 2;
  localparam logic [3:0] KEY_LIFE_CYCLES = 4'h8;
  localparam int unsigned CTRL_GO_BIT = 7;
  localparam int unsigned SEC_BIT = 3;

  // ==========================================================================
  // Addresses and forced-entry code
  localparam logic [15:0] OPTION_TRUE_ADDR = 16'h0FFF;
  localparam logic [15:0] OPTION_ALIAS_ADDR = 16'hFFFF;
  localparam logic [15:0] START_ADDR = 16'h0000;
  localparam logic [23:0] FORCE_CODE = 24'h5E38AC;

  // ==========================================================================
  // Flash operations and command carrier
  typedef enum logic [1:0]
  {
    OP_READ = 2'b00,
    OP_WRITE = 2'b01,
    OP_PAGE_ERASE = 2'b10,
    OP_MASS_ERASE = 2'b11
  } ispfb_op_t;

  typedef struct packed
  {
    ispfb_op_t op;
    logic [15:0] addr;
    logic [7:0] wdata;
  } ispfb_flash_cmd_t;

endpackage

// ==== rtl/ispfb_debounce.sv ====
/*
  Debouncer for the synchronised, active-low service request pin.
  Assumes its input is already in the clk_in domain.
*/
`timescale 1ns/1ps
`default_nettype none
module ispfb_debounce #(
  parameter int unsigned CYCLES = 2500
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Sample and result
  input wire logic enable_in,
  input wire logic level_n_in,
  output logic stable_low_out
);

  logic [15:0] cnt_q;

  // ==========================================================================
  // Count consecutive low samples, restart on any high sample
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_q <= 16'h0000;
      stable_low_out <= 1'b0;
    end
    else if (!enable_in || level_n_in)
    begin
      cnt_q <= 16'h0000;
      stable_low_out <= 1'b0;
    end
    else if (cnt_q == 16'(CYCLES - 1))
    begin
      stable_low_out <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/ispfb_flash_seq.sv ====
/*
  Flash operation sequencer: one strobe per operation, whose width for
  write and erase is sized from the pulse timing value.
  Assumes the flash macro acts while the strobe is high.
*/
`timescale 1ns/1ps
`default_nettype none
module ispfb_flash_seq #(
  parameter int unsigned UNIT = 16
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Request
  input wire logic start_in,
  input wire logic is_read_in,
  input wire logic [6:0] timing_in,
  // Progress
  output logic strobe_out,
  output logic busy_out,
  output logic done_out
);

  typedef enum logic [1:0]
  {
    SQ_IDLE = 2'b00,
    SQ_PULSE = 2'b01,
    SQ_DONE = 2'b10
  } ispfb_seq_t;

  ispfb_seq_t state_q;
  logic [11:0] cnt_q;
  logic [11:0] width_w;

  // Pulse width is (timing + 1) units
  assign width_w = 12'((32'(timing_in) + 32'd1) * UNIT - 32'd1);

  // ==========================================================================
  // Strobe sequence
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_q <= SQ_IDLE;
      cnt_q <= 12'h000;
      strobe_out <= 1'b0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      case (state_q)
        SQ_IDLE:
        begin
          if (start_in)
          begin
            state_q <= SQ_PULSE;
            cnt_q <= is_read_in ? 12'h000 : width_w; // RQ6
            strobe_out <= 1'b1;
            busy_out <= 1'b1;
          end
        end
        SQ_PULSE:
        begin
          if (cnt_q == 12'h000)
          begin
            state_q <= SQ_DONE;
            strobe_out <= 1'b0;
          end
          else
          begin
            cnt_q <= cnt_q - 12'h001;
          end
        end
        SQ_DONE:
        begin
          state_q <= SQ_IDLE;
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end
        default:
        begin
          state_q <= SQ_IDLE;
          strobe_out <= 1'b0;
          busy_out <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== rtl/ispfb_top.sv ====
/*
  ISP support: flash address, data and timing registers,
  flash launch, boot unlock key for the jump-to-boot instruction,
  boot source choice, forced boot entry by a code shifted in
  during reset, and the request pin debounce.
  Assumes a register port and instruction ticks on clk_in, and a
  flash macro that answers a read on the cycle after its strobe.
*/
`timescale 1ns/1ps
`default_nettype none
// Function
// RQ1: Address split in high and low byte registers, both cleared on reset.
// RQ2: Secured option read uses all-ones address, mapped to its true location.
// RQ3: Flash read result lands in the read buffer; no reset value.
// RQ4: Programmed byte comes from the write buffer; no reset value.
// RQ5: Software loads the pulse timing before any write or erase.
// RQ6: Write and erase pulse widths follow the timing register value.
// RQ7: Timing register resets to the 10 MHz encoding.
// RQ8: Software picks the encoding centring its oscillator in the band.
// RQ9: Jump-to-boot enters boot ROM only while key flag set, else flash. A jump made from boot ROM without the flag stays in boot ROM.
// RQ10: Matching key write sets flag for exactly 8 instruction cycles.
// RQ11: Key is bits 7..2 equal to 100110; bits 1..0 ignored.
// RQ12: In emulation a breakpoint freezes the key lifetime counter.
// RQ13: Key lifetime keeps counting during interrupt service.
// RQ14: Software disables interrupts around key arming and boot execution.
// RQ15: Return-to-flash instruction moves execution back to flash.
// RQ16: Forced entry code 5E38AC shifted in LSB first during reset.
// RQ17: Correct code makes reset release start boot ROM at 0000.
// RQ18: A later ordinary reset with boot option set starts flash at 0000.
// RQ19: Forced entry leaves boot-source and security option bits unchanged.
// RQ20: Security bit only cleared by mass erase unless run from flash.
// RQ21: Boot routine waits for request pin low, debounced, then enables.
// RQ22: Host order: power, reset low, shift code, reset high, request low.
// RQ23: Host sends the timing command first in serial programming.
module ispfb_top #(
  parameter int unsigned DEBOUNCE = ispfb_pkg::DEBOUNCE_CYCLES,
  parameter int unsigned PULSE_UNIT = ispfb_pkg::PULSE_UNIT_CYCLES
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Register port
  input wire logic [2:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // Instruction events from the core
  input wire logic instr_tick_in,
  input wire logic jump_to_boot_instr_in,
  input wire logic [15:0] jump_target_in,
  input wire logic return_to_flash_instr_in,
  input wire logic [15:0] return_target_in,
  input wire logic emul_mode_in,
  input wire logic breakpoint_in,
  // Program counter control
  output logic pc_load_out,
  output logic [15:0] pc_target_out,
  output logic exec_boot_out,
  output logic key_flag_out,
  // Option bits and pins
  input wire logic boot_from_flash_opt_in,
  input wire logic security_opt_in,
  input wire logic isp_request_pin_in,
  output logic isp_enable_out,
  // Forced entry link
  input wire logic forced_entry_shift_clock_pin_in,
  input wire logic forced_entry_data_pin_in,
  // Flash macro
  output ispfb_pkg::ispfb_flash_cmd_t flash_cmd_out,
  output logic flash_strobe_out,
  input wire logic [7:0] flash_rdata_in
);

  // ==========================================================================
  // Declarations
  logic rst_meta_q;
  logic rst_n;
  logic [7:0] addr_high_q;
  logic [7:0] addr_low_q;
  logic [7:0] read_buf_q;
  logic [7:0] write_buf_q;
  logic [7:0] pulse_tim_q;
  logic [3:0] key_cnt_q;
  logic [3:0] key_cnt_d;
  logic key_hit;
  logic go;
  logic read_pend_q;
  logic seq_busy;
  logic seq_done;
  logic [15:0] eff_addr;
  logic [7:0] eff_wdata;
  logic [1:0] start_cnt_q;
  logic decided_q;
  logic [23:0] shift_q;
  logic match_q;
  logic match_meta_q;
  logic match_sync_q;
  logic flex_meta_q;
  logic flex_sync_q;
  logic sec_meta_q;
  logic sec_sync_q;
  logic req_meta_q;
  logic req_sync_q;
  logic req_low;

  // ==========================================================================
  // Reset release through two flip-flops
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // ==========================================================================
  // Pin and option synchronisers
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flex_meta_q <= 1'b0;
      flex_sync_q <= 1'b0;
      sec_meta_q <= 1'b0;
      sec_sync_q <= 1'b0;
      req_meta_q <= 1'b1;
      req_sync_q <= 1'b1;
      match_meta_q <= 1'b0;
      match_sync_q <= 1'b0;
    end
    else
    begin
      flex_meta_q <= boot_from_flash_opt_in;
      flex_sync_q <= flex_meta_q;
      sec_meta_q <= security_opt_in;
      sec_sync_q <= sec_meta_q;
      req_meta_q <= isp_request_pin_in;
      req_sync_q <= req_meta_q;
      match_meta_q <= match_q;
      match_sync_q <= match_meta_q;
    end
  end

  // ==========================================================================
  // Forced entry shifter on the shift clock; held clear while core runs
  always_ff @(posedge forced_entry_shift_clock_pin_in or posedge decided_q)
  begin
    if (decided_q)
    begin
      shift_q <= 24'h000000;
      match_q <= 1'b0;
    end
    else
    begin
      shift_q <= {forced_entry_data_pin_in, shift_q[23:1]}; // RQ16
      match_q <= ({forced_entry_data_pin_in, shift_q[23:1]} ==
        ispfb_pkg::FORCE_CODE); // RQ16
    end
  end

  // ==========================================================================
  // Core registers written over the register port
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_high_q <= ispfb_pkg::RST_ADDR; // RQ1
      addr_low_q <= ispfb_pkg::RST_ADDR; // RQ1
      pulse_tim_q <= ispfb_pkg::RST_PULSE_TIM; // RQ7
    end
    else if (reg_wr_in)
    begin
      case (reg_addr_in)
        ispfb_pkg::RA_ADDR_HIGH: addr_high_q <= reg_wdata_in; // RQ1
        ispfb_pkg::RA_ADDR_LOW: addr_low_q <= reg_wdata_in; // RQ1
        ispfb_pkg::RA_PULSE_TIM:
          pulse_tim_q <= reg_wdata_in & ispfb_pkg::PULSE_TIM_RW_MASK;
        default: ;
      endcase
    end
  end

  // Data buffers carry no reset value
  always_ff @(posedge clk_in)
  begin
    if (reg_wr_in && reg_addr_in == ispfb_pkg::RA_WRITE_BUF)
      write_buf_q <= reg_wdata_in; // RQ4
    if (read_pend_q && seq_done)
      read_buf_q <= flash_rdata_in; // RQ3
  end

  // ==========================================================================
  // Flash operation launch
  assign go = reg_wr_in && reg_addr_in == ispfb_pkg::RA_CONTROL &&
    reg_wdata_in[ispfb_pkg::CTRL_GO_BIT] && !seq_busy;

  // Secured option read via the alias address
  always_comb
  begin
    eff_addr = {addr_high_q, addr_low_q};
    if (eff_addr == ispfb_pkg::OPTION_ALIAS_ADDR && sec_sync_q)
      eff_addr = ispfb_pkg::OPTION_TRUE_ADDR; // RQ2
  end

  // Boot routines cannot clear a set security bit by a byte write
  always_comb
  begin
    eff_wdata = write_buf_q; // RQ4
    if (exec_boot_out && sec_sync_q &&
        eff_addr == ispfb_pkg::OPTION_TRUE_ADDR)
      eff_wdata[ispfb_pkg::SEC_BIT] = 1'b1; // RQ20
  end

  // Command latched at launch, held for the whole operation
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flash_cmd_out <= '0;
      read_pend_q <= 1'b0;
    end
    else if (go)
    begin
      flash_cmd_out.op <= ispfb_pkg::ispfb_op_t'(reg_wdata_in[1:0]);
      flash_cmd_out.addr <= eff_addr; // RQ2
      flash_cmd_out.wdata <= eff_wdata; // RQ20
      read_pend_q <= (reg_wdata_in[1:0] == ispfb_pkg::OP_READ);
    end
    else if (seq_done)
    begin
      read_pend_q <= 1'b0;
    end
  end

  // Pulse sequencer
  ispfb_flash_seq #(
    .UNIT(PULSE_UNIT)
  ) u_seq (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .start_in(go),
    .is_read_in(reg_wdata_in[1:0] == ispfb_pkg::OP_READ),
    .timing_in(pulse_tim_q[6:0]),
    .strobe_out(flash_strobe_out),
    .busy_out(seq_busy),
    .done_out(seq_done)
  );

  // ==========================================================================
  // Unlock key lifetime
  assign key_hit = reg_wr_in && reg_addr_in == ispfb_pkg::RA_UNLOCK;

  always_comb
  begin
    key_cnt_d = key_cnt_q;
    if (key_hit)
    begin
      if (reg_wdata_in[7:ispfb_pkg::UNLOCK_KEY_LSB] ==
          ispfb_pkg::UNLOCK_KEY) // RQ11
        key_cnt_d = ispfb_pkg::KEY_LIFE_CYCLES; // RQ10
      else
        key_cnt_d = 4'h0; // RQ10
    end
    else if (jump_to_boot_instr_in)
      key_cnt_d = 4'h0;
    else if (instr_tick_in && key_cnt_q != 4'h0 &&
             !(emul_mode_in && breakpoint_in)) // RQ12
      key_cnt_d = key_cnt_q - 4'h1; // RQ13
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      key_cnt_q <= 4'h0;
      key_flag_out <= 1'b0;
    end
    else
    begin
      key_cnt_q <= key_cnt_d;
      key_flag_out <= (key_cnt_d != 4'h0); // RQ10
    end
  end

  // ==========================================================================
  // Boot source decision after reset, then instruction-driven transfers
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start_cnt_q <= 2'h0;
      decided_q <= 1'b0;
      exec_boot_out <= 1'b0;
      pc_load_out <= 1'b0;
      pc_target_out <= ispfb_pkg::START_ADDR;
    end
    else
    begin
      pc_load_out <= 1'b0;
      if (!decided_q)
      begin
        if (start_cnt_q == ispfb_pkg::STARTUP_CYCLES)
        begin
          decided_q <= 1'b1;
          exec_boot_out <= match_sync_q || !flex_sync_q; // RQ17 RQ18 RQ19
          pc_target_out <= ispfb_pkg::START_ADDR; // RQ17
          pc_load_out <= 1'b1;
        end
        else
        begin
          start_cnt_q <= start_cnt_q + 2'h1;
        end
      end
      else if (jump_to_boot_instr_in)
      begin
        exec_boot_out <= exec_boot_out || key_flag_out; // RQ9
        pc_target_out <= jump_target_in; // RQ9
        pc_load_out <= 1'b1;
      end
      else if (return_to_flash_instr_in)
      begin
        exec_boot_out <= 1'b0; // RQ15
        pc_target_out <= return_target_in; // RQ15
        pc_load_out <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Service request: debounced low while in boot ROM
  ispfb_debounce #(
    .CYCLES(DEBOUNCE)
  ) u_deb (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .enable_in(exec_boot_out),
    .level_n_in(req_sync_q),
    .stable_low_out(req_low)
  );

  // Enable holds once granted until execution leaves boot ROM
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      isp_enable_out <= 1'b0;
    else if (!exec_boot_out)
      isp_enable_out <= 1'b0;
    else if (req_low)
      isp_enable_out <= 1'b1; // RQ21
  end

  // ==========================================================================
  // Register read data, captured on the read strobe
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata_out <= 8'h00;
    else if (reg_rd_in)
    begin
      case (reg_addr_in)
        ispfb_pkg::RA_ADDR_HIGH: reg_rdata_out <= addr_high_q;
        ispfb_pkg::RA_ADDR_LOW: reg_rdata_out <= addr_low_q;
        ispfb_pkg::RA_READ_BUF: reg_rdata_out <= read_buf_q; // RQ3
        ispfb_pkg::RA_WRITE_BUF: reg_rdata_out <= write_buf_q;
        ispfb_pkg::RA_PULSE_TIM: reg_rdata_out <= pulse_tim_q;
        ispfb_pkg::RA_STATUS:
          reg_rdata_out <= {4'h0, isp_enable_out, seq_busy,
            key_flag_out, exec_boot_out};
        default: reg_rdata_out <= 8'h00; // Key and control read zero
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== testbench/ispfb_top_sva.sv ====
/*
  Checker for ispfb_top: unlock key life, jumps, flash strobe, request.
  Assumes it is bound to ispfb_top and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
module ispfb_top_sva #(
  parameter int unsigned DEBOUNCE = 4,
  parameter int unsigned PULSE_UNIT = 1
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Register port and core events
  input wire logic [2:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic instr_tick_in,
  input wire logic jump_to_boot_instr_in,
  input wire logic [15:0] jump_target_in,
  input wire logic return_to_flash_instr_in,
  input wire logic [15:0] return_target_in,
  input wire logic emul_mode_in,
  input wire logic breakpoint_in,
  input wire logic security_opt_in,
  input wire logic isp_request_pin_in,
  // Design outputs
  input wire logic pc_load_out,
  input wire logic [15:0] pc_target_out,
  input wire logic exec_boot_out,
  input wire logic key_flag_out,
  input wire logic isp_enable_out,
  input wire ispfb_pkg::ispfb_flash_cmd_t flash_cmd_out,
  input wire logic flash_strobe_out
);
  // ==========================================================================
  // Helper state
  logic key_wr;
  logic [3:0] life_q;
  logic [7:0] pt_q;
  int hi_q, low_q;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  // Key register write strobe
  assign key_wr = reg_wr_in && reg_addr_in == ispfb_pkg::RA_UNLOCK;

  // Armed ticks, timing copy, strobe width, request low time
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      life_q <= 4'h0;
      pt_q <= ispfb_pkg::RST_PULSE_TIM;
      hi_q <= 0;
      low_q <= 0;
    end
    else
    begin
      if (key_wr)
        life_q <= 4'h0;
      else if (key_flag_out && instr_tick_in && !(emul_mode_in && breakpoint_in))
        life_q <= life_q + 4'h1;
      if (reg_wr_in && reg_addr_in == ispfb_pkg::RA_PULSE_TIM)
        pt_q <= reg_wdata_in;
      hi_q <= flash_strobe_out ? hi_q + 1 : 0;
      low_q <= isp_request_pin_in ? 0 : low_q + 1;
    end
  end

  // ==========================================================================
  // Assertions
  key_arm_a: assert property (key_wr && reg_wdata_in[7:2] == 6'h26
    |=> key_flag_out) else $error("key not armed");
  key_bad_a: assert property (key_wr && reg_wdata_in[7:2] != 6'h26
    |=> !key_flag_out) else $error("bad key armed");
  key_life_a: assert property (key_flag_out |-> life_q < 4'h8)
    else $error("key too long");
  key_hold_a: assert property ($fell(key_flag_out) &&
    !$past(jump_to_boot_instr_in) && !$past(key_wr) |-> life_q == 4'h8)
    else $error("key dropped early");
  jump_boot_a: assert property (jump_to_boot_instr_in && key_flag_out
    |=> pc_load_out && exec_boot_out && pc_target_out == $past(jump_target_in))
    else $error("no boot jump");
  jump_flash_a: assert property (jump_to_boot_instr_in &&
    !key_flag_out && !exec_boot_out |=> pc_load_out ##0 !exec_boot_out)
    else $error("boot without key");
  return_a: assert property (return_to_flash_instr_in |=> pc_load_out &&
    !exec_boot_out && pc_target_out == $past(return_target_in))
    else $error("no return");
  read_pulse_a: assert property ($rose(flash_strobe_out) &&
    flash_cmd_out.op == ispfb_pkg::OP_READ |=> !flash_strobe_out)
    else $error("read strobe long");
  pulse_width_a: assert property ($fell(flash_strobe_out) &&
    flash_cmd_out.op != ispfb_pkg::OP_READ
    |-> hi_q == (int'(pt_q[6:0]) + 1) * PULSE_UNIT)
    else $error("pulse width wrong");
  option_alias_a: assert property ($rose(flash_strobe_out) &&
    security_opt_in && $past(security_opt_in, 3)
    |-> flash_cmd_out.addr != 16'hFFFF) else $error("alias leaked");
  req_debounce_a: assert property ($rose(isp_enable_out)
    |-> exec_boot_out && low_q >= DEBOUNCE) else $error("not debounced");

  // Main scenarios reached
  cover property ($fell(key_flag_out));
  cover property ($rose(isp_enable_out));
  cover property ($fell(flash_strobe_out) &&
    flash_cmd_out.op == ispfb_pkg::OP_MASS_ERASE);
endmodule

bind ispfb_top ispfb_top_sva #(.DEBOUNCE(DEBOUNCE), .PULSE_UNIT(PULSE_UNIT))
  i_ispfb_top_sva (.*);
`default_nettype wire

// ==== testbench/ispfb_host_model.sv ====
/*
  Host model: shifts a 24-bit code into the forced entry pins.
  Assumes the core is held in reset during a frame.
*/
`timescale 1ns/1ps
`default_nettype none
module ispfb_host_model
(
  // Frame request
  input wire logic start_in,
  input wire logic [23:0] code_in,
  output logic busy_out,
  // Forced entry pins
  output logic shift_clock_out,
  output logic data_out
);
  // ==========================================================================
  // Idle levels at power up
  initial
  begin
    busy_out = 1'b0;
    shift_clock_out = 1'b0;
    data_out = 1'b0;
  end

  // One frame: 32 ns clock only inside it, least significant bit first
  always @(posedge start_in)
  begin
    busy_out = 1'b1;
    #3;
    for (int i = 0; i < 24; i++)
    begin
      data_out = code_in[i];
      #8 shift_clock_out = 1'b1;
      #16 shift_clock_out = 1'b0;
      #8;
    end
    // Released data line shows the inverse of the last bit
    data_out = ~data_out;
    busy_out = 1'b0;
  end
endmodule
`default_nettype wire

// ==== testbench/isp_flash_access_and_boot_entry_tb.sv ====
/*
  Testbench for ispfb_top: boot choice, registers, flash ops, key, jumps.
  Assumes the host model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      num_errors++; \
      $display("CHECK FAILED %s exp %0h got %0h", n, e, g); \
    end \
  end
module isp_flash_access_and_boot_entry_tb;
  // ==========================================================================
  // Stimulus and observed signals
  logic clk_in = 0, rstn_in = 0, reg_wr_in = 0, reg_rd_in = 0;
  logic instr_tick_in = 0, jump_to_boot_instr_in = 0, emul_mode_in = 0;
  logic return_to_flash_instr_in = 0, breakpoint_in = 0, host_go = 0;
  logic boot_from_flash_opt_in = 1, security_opt_in = 1;
  logic isp_request_pin_in = 1, host_busy, pc_load_out, exec_boot_out;
  logic key_flag_out, isp_enable_out, flash_strobe_out;
  logic forced_entry_shift_clock_pin_in, forced_entry_data_pin_in;
  logic [2:0] reg_addr_in = 0;
  logic [7:0] reg_wdata_in = 0, flash_rdata_in = 8'h3C, reg_rdata_out;
  logic [15:0] jump_target_in = 0, return_target_in = 0, pc_target_out;
  logic [23:0] code = 0;
  ispfb_pkg::ispfb_flash_cmd_t flash_cmd_out;
  int num_errors = 0;
  int total_checks = 0;
  int cyc = 0;

  // Device and programming host
  ispfb_top #(.DEBOUNCE(4), .PULSE_UNIT(1)) i_ispfb_top (.*);
  ispfb_host_model i_ispfb_host_model (.start_in(host_go), .code_in(code),
    .busy_out(host_busy), .shift_clock_out(forced_entry_shift_clock_pin_in),
    .data_out(forced_entry_data_pin_in));

  // 25 MHz clock and hang guard
  always #20 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    if (++cyc == 20000)
    begin
      num_errors++;
      summarize();
    end
  end

  // ==========================================================================
  // Register port and core event tasks
  task summarize;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask
  task rd_chk(input string n, input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 `CHK(n, e, reg_rdata_out)
  endtask
  task launch(input logic [1:0] op, input logic [15:0] ad);
    int n;
    wr(3'h6, {6'h20, op});
    @(posedge clk_in);
    #1 `CHK("flash_op", op, flash_cmd_out.op)
    `CHK("flash_addr", ad, flash_cmd_out.addr)
    n = 0;
    do
      @(posedge clk_in);
    while (flash_strobe_out !== 1'b0 && ++n < 300);
    repeat (3) @(posedge clk_in);
  endtask
  task tick(input int n);
    repeat (n)
    begin
      @(posedge clk_in);
      instr_tick_in <= 1'b1;
      @(posedge clk_in);
      instr_tick_in <= 1'b0;
    end
    #1;
  endtask
  task pc_evt(input logic j, input logic [15:0] t, input logic e);
    @(posedge clk_in);
    jump_to_boot_instr_in <= j;
    return_to_flash_instr_in <= ~j;
    jump_target_in <= t;
    return_target_in <= t;
    @(posedge clk_in);
    jump_to_boot_instr_in <= 1'b0;
    return_to_flash_instr_in <= 1'b0;
    #1 `CHK("pc_target", t, pc_target_out)
    `CHK("boot_side", e, exec_boot_out)
  endtask
  task boot(input logic forced, input logic [23:0] c, input logic e);
    int n;
    @(posedge clk_in);
    rstn_in <= 1'b0;
    code <= c;
    host_go <= forced;
    repeat (2) @(posedge clk_in);
    host_go <= 1'b0;
    n = 0;
    while (host_busy && ++n < 100)
      @(posedge clk_in);
    @(posedge clk_in);
    rstn_in <= 1'b1;
    n = 0;
    do
      @(posedge clk_in);
    while (pc_load_out !== 1'b1 && ++n < 20);
    #1 `CHK("boot_side", e, exec_boot_out)
    `CHK("start_addr", 16'h0000, pc_target_out)
  endtask

  // ==========================================================================
  // Test sequence
  initial
  begin
    boot(1'b1, ispfb_pkg::FORCE_CODE, 1'b1);
    boot(1'b0, 24'h0, 1'b0);
    boot(1'b1, ispfb_pkg::FORCE_CODE, 1'b1);
    rd_chk("addr_high", 3'h0, 8'h00);
    rd_chk("addr_low", 3'h1, 8'h00);
    rd_chk("pulse_tim", 3'h4, 8'h5A);
    $display("test boot_choice done");
    isp_request_pin_in <= 1'b0;
    repeat (12) @(posedge clk_in);
    rd_chk("status", 3'h7, 8'h09);
    $display("test request_pin done");
    wr(3'h4, 8'hFF);
    rd_chk("pulse_tim", 3'h4, 8'h7F);
    wr(3'h0, 8'hFF);
    wr(3'h1, 8'hFF);
    launch(2'h0, 16'h0FFF);
    wr(3'h2, 8'h00);
    rd_chk("read_buf", 3'h2, 8'h3C);
    wr(3'h4, 8'h01);
    wr(3'h3, 8'hA5);
    wr(3'h0, 8'h01);
    wr(3'h1, 8'h23);
    rd_chk("write_buf", 3'h3, 8'hA5);
    for (int o = 1; o < 4; o++)
      launch(o[1:0], 16'h0123);
    `CHK("wdata", 8'hA5, flash_cmd_out.wdata)
    $display("test flash_ops done");
    pc_evt(1'b0, 16'h0200, 1'b0);
    wr(3'h5, 8'h9B);
    `CHK("key", 1'b1, key_flag_out)
    tick(7);
    `CHK("key", 1'b1, key_flag_out)
    tick(1);
    `CHK("key", 1'b0, key_flag_out)
    wr(3'h5, 8'h9C);
    `CHK("key", 1'b0, key_flag_out)
    pc_evt(1'b1, 16'h0300, 1'b0);
    wr(3'h5, 8'h98);
    emul_mode_in <= 1'b1;
    breakpoint_in <= 1'b1;
    tick(10);
    `CHK("key", 1'b1, key_flag_out)
    emul_mode_in <= 1'b0;
    breakpoint_in <= 1'b0;
    tick(3);
    pc_evt(1'b1, 16'h0040, 1'b1);
    $display("test key_jumps done");
    boot(1'b1, ispfb_pkg::FORCE_CODE ^ 24'h000001, 1'b0);
    $display("test bad_code done");
    summarize();
  end
endmodule
`default_nettype wire
